// >>> design/wss_map.svh
// Register indices, field positions, reset values and timing counts of the slot sequencer
`ifndef WSS_MAP_SVH
`define WSS_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define WSS_IDX_GO        6'h0C
`define WSS_IDX_SLOT1     6'h0F
`define WSS_IDX_SLOT7     6'h15
`define WSS_IDX_SLOT8     6'h16
`define WSS_IDX_LOOP_LO   6'h17
`define WSS_IDX_LOOP_HI   6'h18
`define WSS_IDX_STATUS    6'h19

// Field positions
`define WSS_GO_BIT        0
`define WSS_FLAG_BIT      7
`define WSS_SEL_MSB       6
`define WSS_ST_BUSY_BIT   0
`define WSS_ST_SLOT_LSB   1
`define WSS_ST_PASS_LSB   4

// Counts and reset values
`define WSS_NUM_SLOTS     8
`define WSS_NUM_REGS      10
`define WSS_LAST_SLOT     3'h7
`define WSS_RST_BYTE      8'h00
`define WSS_RST_WORD      32'h0000_0000

// Timing: 10 ms tick at 25 MHz
`define WSS_CLK_HZ        25000000
`define WSS_TICK_MS       10
`define WSS_TICK_CYCLES   ((`WSS_CLK_HZ / 1000) * `WSS_TICK_MS)

`endif

// >>> design/wss_pkg.sv
// Types shared by the slot sequencer files
package wss_pkg;

  typedef enum logic [2:0] {
    WSS_IDLE  = 3'b000,
    WSS_FETCH = 3'b001,
    WSS_PLAY  = 3'b010,
    WSS_DELAY = 3'b011,
    WSS_NEXT  = 3'b100
  } wss_state_e;

  typedef struct packed {
    logic       delay_flag;
    logic [6:0] selector;
  } wss_slot_s;

  typedef struct packed {
    logic       start;
    logic       abort;
    logic [6:0] index;
  } wss_play_s;

endpackage : wss_pkg

// >>> design/wss_reg8.sv
// One byte-wide software register with synchronous reset and write strobe
`timescale 1ns/10ps
`default_nettype none

module wss_reg8
  import wss_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);

  typedef struct packed {
    logic [7:0] value;
  } wss_reg8_s;

  wss_reg8_s q;
  wss_reg8_s next_q;

  always_comb
  begin
    next_q = q;
    if (we_i)
    begin
      next_q.value = wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.value <= RESET_VALUE;
    end
    else if (ce_i)
    begin
      q <= next_q;
    end
  end

  assign q_o = q.value;

endmodule : wss_reg8

`default_nettype wire

// >>> design/wss_seq.sv
// Waveform slot sequencer with its Wishbone register file
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

`include "wss_map.svh"

//
// Contract
// R1: Flag set: value means idle time of value times ten milliseconds, no waveform.
// R2: Flag clear: value is a waveform selector played in the sequence.
// R3: Selector is an integer index into the stored waveform library.
// R4: Software sets trigger bit at 0x0C; sequencing then starts at slot 0x0F.
// R5: After a slot finishes, advance in address order if next selector nonzero.
// R6: Finish after the eighth slot at sequence_slot_eight, or earlier at a zero selector.
// R7: Zero selector is a stop marker; nothing is played for it.
// R8: Each slot plays its repeat count plus one times before advancing.
// R9: Ten millisecond tick from the clock counts delays; zero count gives none.
module wss_seq
  import wss_pkg::*;
#(
  parameter int TICK_CYCLES = `WSS_TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output wss_play_s        play_o,
  input  wire logic        play_done_i,
  output logic             busy_o,
  output logic      [2:0]  slot_o
);

  typedef struct packed {
    wss_state_e  state;
    logic        go;
    logic [2:0]  slot;
    logic [1:0]  pass;
    logic [6:0]  remaining;
    logic        ack;
    logic [31:0] rdata;
    wss_play_s   play;
  } wss_seq_s;

  wss_seq_s     q;
  wss_seq_s     next_q;

  logic [7:0]   reg_q [0:`WSS_NUM_REGS-1];
  logic [`WSS_NUM_REGS-1:0] reg_we;
  logic         tick;
  logic         tick_clear;
  logic [5:0]   idx;
  logic         bus_req;
  logic         bus_write;
  logic         go_write;
  wss_slot_s    cur_slot;
  logic [7:0]   loop_byte;
  logic [1:0]   cur_repeat;
  logic [3:0]   reg_sel;
  logic         in_slot_range;

  assign idx       = wb_adr_i[7:2];
  assign bus_req   = wb_cyc_i && wb_stb_i;
  // Writes land on the edge that ends the ack cycle, so the master sees them once
  assign bus_write = bus_req && wb_we_i && wb_sel_i[0] && q.ack;
  assign go_write  = bus_write && (idx == `WSS_IDX_GO);
  assign in_slot_range = (idx >= `WSS_IDX_SLOT1) && (idx <= `WSS_IDX_LOOP_HI);
  assign reg_sel   = 4'(idx - `WSS_IDX_SLOT1);

  // Slot and repeat-count registers occupy ten consecutive indices
  genvar gi;
  generate
    for (gi = 0; gi < `WSS_NUM_REGS; gi++)
    begin : g_reg
      assign reg_we[gi] = bus_write && (idx == 6'(`WSS_IDX_SLOT1 + gi));
      wss_reg8 #(
        .RESET_VALUE (`WSS_RST_BYTE)
      ) u_reg (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .we_i    (reg_we[gi]),
        .wdata_i (wb_dat_i[7:0]),
        .q_o     (reg_q[gi])
      );
    end
  endgenerate

  wss_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .clear_i (tick_clear),
    .tick_o  (tick)
  );

  // Slot registers are read live, so software edits to later slots take
  // effect if they land before the sequencer reaches them
  assign cur_slot   = wss_slot_s'(reg_q[q.slot]);
  assign loop_byte  = q.slot[2] ? reg_q[`WSS_NUM_REGS-1] : reg_q[`WSS_NUM_REGS-2];
  assign cur_repeat = 2'(loop_byte >> {q.slot[1:0], 1'b0});
  assign tick_clear = (q.state != WSS_DELAY);

  always_comb
  begin
    next_q = q;
    next_q.play.start = 1'b0;
    next_q.play.abort = 1'b0;

    // Bus answer: one wait state, ack dropped the cycle after it is given
    next_q.ack   = bus_req && !q.ack;
    next_q.rdata = `WSS_RST_WORD;
    if (bus_req && !q.ack && !wb_we_i)
    begin
      if (idx == `WSS_IDX_GO)
      begin
        next_q.rdata[`WSS_GO_BIT] = q.go;
      end
      else if (in_slot_range)
      begin
        next_q.rdata[7:0] = reg_q[reg_sel];
      end
      else if (idx == `WSS_IDX_STATUS)
      begin
        next_q.rdata[`WSS_ST_BUSY_BIT] = (q.state != WSS_IDLE);
        next_q.rdata[`WSS_ST_SLOT_LSB +: 3] = q.slot;
        next_q.rdata[`WSS_ST_PASS_LSB +: 2] = q.pass;
      end
    end

    case (q.state)
      WSS_IDLE:
      begin
        if (q.go)
        begin
          next_q.slot  = 3'h0; // R4
          next_q.pass  = 2'h0;
          next_q.state = WSS_FETCH;
        end
      end
      WSS_FETCH:
      begin
        if (!cur_slot.delay_flag && cur_slot.selector == 7'h00)
        begin
          next_q.go    = 1'b0; // R7
          next_q.state = WSS_IDLE;
        end
        else if (cur_slot.delay_flag)
        begin
          next_q.remaining = cur_slot.selector; // R1
          next_q.state     = (cur_slot.selector == 7'h00) ? WSS_NEXT : WSS_DELAY; // R9
        end
        else
        begin
          next_q.play.start = 1'b1; // R2
          next_q.play.index = cur_slot.selector; // R3
          next_q.state      = WSS_PLAY;
        end
      end
      WSS_PLAY:
      begin
        if (play_done_i)
        begin
          next_q.state = WSS_NEXT;
        end
      end
      WSS_DELAY:
      begin
        if (tick)
        begin
          next_q.remaining = q.remaining - 7'h01; // R9
          if (q.remaining == 7'h01)
          begin
            next_q.state = WSS_NEXT; // R1
          end
        end
      end
      WSS_NEXT:
      begin
        if (q.pass != cur_repeat)
        begin
          next_q.pass  = q.pass + 2'h1; // R8
          next_q.state = WSS_FETCH;
        end
        else if (q.slot == `WSS_LAST_SLOT)
        begin
          next_q.go    = 1'b0; // R6
          next_q.state = WSS_IDLE;
        end
        else
        begin
          next_q.slot  = q.slot + 3'h1; // R5
          next_q.pass  = 2'h0;
          next_q.state = WSS_FETCH;
        end
      end
      default:
      begin
        next_q.state = WSS_IDLE;
      end
    endcase

    // Clearing the trigger mid-sequence aborts playback from WSS_PLAY only; a start from WSS_FETCH in that cycle still goes out
    if (q.state != WSS_IDLE && !q.go)
    begin
      next_q.play.abort = (q.state == WSS_PLAY);
      next_q.state      = WSS_IDLE;
    end

    // A software write outranks the sequencer's own clear at the finish
    if (go_write)
    begin
      next_q.go = wb_dat_i[`WSS_GO_BIT]; // R4
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.state     <= WSS_IDLE;
      q.go        <= 1'b0;
      q.slot      <= 3'h0;
      q.pass      <= 2'h0;
      q.remaining <= 7'h00;
      q.ack       <= 1'b0;
      q.rdata     <= `WSS_RST_WORD;
      q.play      <= '0;
    end
    else if (ce_i)
    begin
      q <= next_q;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign play_o   = q.play;
  assign busy_o   = (q.state != WSS_IDLE);
  assign slot_o   = q.slot;

endmodule : wss_seq

`default_nettype wire

// >>> design/wss_tick.sv
// Prescaler that yields one pulse every TICK_CYCLES clocks while running
`timescale 1ns/10ps
`default_nettype none

module wss_tick
  import wss_pkg::*;
#(
  parameter int TICK_CYCLES = 250000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic clear_i,
  output logic      tick_o
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } wss_tick_s;

  wss_tick_s q;
  wss_tick_s next_q;

  // Clear restarts the period so a delay is a whole number of ticks
  always_comb
  begin
    next_q = q;
    if (clear_i || q.count == LAST)
    begin
      next_q.count = '0;
    end
    else
    begin
      next_q.count = q.count + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.count <= '0;
    end
    else if (ce_i)
    begin
      q <= next_q;
    end
  end

  assign tick_o = !clear_i && (q.count == LAST);

endmodule : wss_tick

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the slot sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import wss_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic        ack, done, busy;
  logic [2:0]  slot;
  wss_play_s   play;
  int          fails = 0, checked = 0;
  logic [31:0] rq[$];
  logic [6:0]  pq[$];

  wss_seq #(.TICK_CYCLES(4)) dut_u (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .play_o(play), .play_done_i(done), .busy_o(busy),
    .slot_o(slot));
  wss_player_model pm_u (.clk_i, .play_i(play), .done_o(done));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic wb(logic w, logic [5:0] idx, logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      fails++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Results are taken in the cycle they stand, before that edge's updates land
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk("read data", (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_BEEF, rdat);
    if (play.start === 1'b1)
      chk("played index", (pq.size() > 0) ? {25'h0, pq.pop_front()} : 32'hFFFF_FFFF,
        {25'h0, play.index});
  end

  initial
  begin
    #(40 * 20000);
    fails++;
    print_verdict();
  end

  initial
  begin
    logic [7:0] sel [8];
    logic [7:0] rep [2];
    logic [5:0] ridx [5] = '{6'h0C, 6'h15, 6'h16, 6'h18, 6'h3F};
    int stop, dly, n;
    void'($urandom(63));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ridx[i])
    begin
      rq.push_back(32'h0000_0000);
      wb(1'b0, ridx[i], 32'h0000_0000);
    end
    // Run 1 stops early at a zero slot; runs 0 and 2 put a delay in slot 7 or 8
    for (int run = 0; run < 3; run++)
    begin
      stop = (run == 1) ? 2 : 8;
      dly = (run == 2) ? 7 : 6;
      for (int i = 0; i < 8; i++)
      begin
        sel[i] = {1'b0, 7'($urandom_range(127, 1))};
        if (i == dly)
          sel[i] = {1'b1, 7'($urandom_range(3, 0))};
        if (i == stop)
          sel[i] = 8'h00;
        wb(1'b1, 6'h0F + 6'(i), {24'($urandom()), sel[i]});
        if (i >= 6)
        begin
          rq.push_back({24'h00_0000, sel[i]});
          wb(1'b0, 6'h0F + 6'(i), 32'h0000_0000);
        end
      end
      rep[0] = 8'($urandom());
      rep[1] = 8'($urandom());
      wb(1'b1, 6'h17, {24'h00_0000, rep[0]});
      wb(1'b1, 6'h18, {24'h00_0000, rep[1]});
      for (int i = 0; i < stop; i++)
        for (int r = 0; r <= int'(rep[i / 4][2 * (i % 4) +: 2]); r++)
          if (!sel[i][7])
            pq.push_back(sel[i][6:0]);
      wb(1'b1, 6'h0C, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      n = 0;
      while (busy !== 1'b0 && n < 5000)
      begin
        @(posedge clk_i);
        n++;
      end
      if (n == 5000)
      begin
        fails++;
        print_verdict();
      end
      chk("plays left", 32'h0000_0000, 32'(pq.size()));
      rq.push_back(32'h0000_0000);
      wb(1'b0, 6'h0C, 32'h0000_0000);
    end
    chk("reads left", 32'h0000_0000, 32'(rq.size()));
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// >>> test/wss_player_model.sv
// Waveform player that answers each start pulse with a done pulse
`timescale 1ns/10ps
`default_nettype none
module wss_player_model
  import wss_pkg::*;
(
  input  wire logic      clk_i,
  input  wire wss_play_s play_i,
  output logic           done_o
);
  int cnt = 0;
  initial done_o = 1'b0;
  // Random latency so the sequencer meets both prompt and slow players
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (play_i.start)
      cnt = $urandom_range(6, 1);
    else if (cnt > 0)
    begin
      cnt--;
      if (cnt == 0)
        done_o <= 1'b1;
    end
  end
endmodule : wss_player_model
`default_nettype wire

// >>> test/wss_seq_monitor.sv
// Port checker for the slot sequencer
`timescale 1ns/10ps
`default_nettype none
module wss_seq_monitor
  import wss_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire wss_play_s   play_o,
  input wire logic        busy_o,
  input wire logic [2:0]  slot_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  start_pulse_a: assert property (play_o.start |=> !play_o.start)
    else $error("start too long");
  start_busy_a: assert property (play_o.start |-> busy_o) else $error("start while idle");
  start_nonzero_a: assert property (play_o.start |-> play_o.index != 7'h00)
    else $error("zero index played");
  slot_step_a: assert property ($changed(slot_o) |->
    slot_o == 3'($past(slot_o) + 3'h1) || slot_o == 3'h0) else $error("slot skipped");
  busy_first_a: assert property ($rose(busy_o) |-> slot_o == 3'h0)
    else $error("not started at first slot");
  cover property (play_o.start);
  cover property ($fell(busy_o));
  cover property (busy_o && slot_o == 3'h7);
endmodule : wss_seq_monitor
bind wss_seq wss_seq_monitor mon_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .play_o, .busy_o, .slot_o);
`default_nettype wire
